// >>> core/crc_generator.sv
// programmable serial crc generator with input fifo and register port
`timescale 1ns/1ps
`include "crc_defs.svh"

module crc_generator
	import crc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic idleMode,
	input wire crc_sfr_req_t sfrReq,
	output logic [15:0] sfrRdData,
	output logic crcIrq
);
	logic moduleEnable_reg;
	logic idleStop_reg;
	logic irqSel_reg;
	logic goBit_reg;
	logic lsbFirst_reg;
	logic [4:0] dataWidth_reg;
	logic [4:0] polyLen_reg;
	logic [31:1] polyTerms_reg;
	logic [15:0] dataHigh_reg;
	logic [31:0] fifoMem [0:`CRC_FIFO_SLOTS-1];
	logic [3:0] wrPtr_reg;
	logic [3:0] rdPtr_reg;
	logic [4:0] wordCount_reg;
	logic [4:0] wordCount_next;
	logic fullFlag_reg;
	logic emptyFlag_reg;
	crc_state_t state_reg;
	logic [31:0] word_reg;
	logic [4:0] bitCnt_reg;
	logic [31:0] shift_reg;
	logic [31:0] shift_next;
	logic [31:0] lenMask;
	logic [4:0] capacity;
	logic isFull;
	logic pushNow;
	logic popNow;
	logic doneNow;
	logic engineRun;
	logic bitIn;
	logic feedback;
	logic [31:0] pushWord;
	logic [15:0] rdValue;
	logic [15:0] rdData_reg;
	logic irq_reg;

	wire wrCtrlOne = sfrReq.wrEn && sfrReq.addr == `CRC_IDX_CTRL_ONE;
	wire wrCtrlTwo = sfrReq.wrEn && sfrReq.addr == `CRC_IDX_CTRL_TWO;
	wire wrTermsLow = sfrReq.wrEn && sfrReq.addr == `CRC_IDX_TERMS_LOW;
	wire wrTermsHigh = sfrReq.wrEn && sfrReq.addr == `CRC_IDX_TERMS_HIGH;
	wire wrDataLow = sfrReq.wrEn && sfrReq.addr == `CRC_IDX_DATA_LOW;
	wire wrDataHigh = sfrReq.wrEn && sfrReq.addr == `CRC_IDX_DATA_HIGH;
	wire wrResLow = sfrReq.wrEn && sfrReq.addr == `CRC_IDX_RESULT_LOW;
	wire wrResHigh = sfrReq.wrEn && sfrReq.addr == `CRC_IDX_RESULT_HIGH;
	wire wideData = dataWidth_reg > `CRC_WIDTH_MEDIUM_MAX;

	// control registers; unimplemented bits are simply not stored
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			moduleEnable_reg <= 1'b0;
			idleStop_reg <= 1'b0;
			irqSel_reg <= 1'b0;
			goBit_reg <= 1'b0;
			lsbFirst_reg <= 1'b0;
		end else if (wrCtrlOne) begin
			moduleEnable_reg <= sfrReq.wrData[`CRC_BIT_ENABLE];
			idleStop_reg <= sfrReq.wrData[`CRC_BIT_IDLE_STOP];
			irqSel_reg <= sfrReq.wrData[`CRC_BIT_IRQ_SEL];
			goBit_reg <= sfrReq.wrData[`CRC_BIT_GO];
			lsbFirst_reg <= sfrReq.wrData[`CRC_BIT_LSB_FIRST];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dataWidth_reg <= 5'h00;
			polyLen_reg <= 5'h00;
		end else if (wrCtrlTwo) begin
			dataWidth_reg <= sfrReq.wrData[`CRC_WIDTH_LSB +: 5];
			polyLen_reg <= sfrReq.wrData[`CRC_LEN_LSB +: 5];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			polyTerms_reg <= 31'h00000000;
		end else begin
			if (wrTermsLow) begin
				polyTerms_reg[15:1] <= sfrReq.wrData[15:1];
			end
			if (wrTermsHigh) begin
				polyTerms_reg[31:16] <= sfrReq.wrData;
			end
		end
	end

	// high half is staged only for widths above 15; a low write pushes the whole word
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dataHigh_reg <= 16'h0000;
		end else if (wrDataHigh && wideData) begin
			dataHigh_reg <= sfrReq.wrData;
		end
	end

	// fifo depth by data width
	always_comb begin
		if (dataWidth_reg <= `CRC_WIDTH_NARROW_MAX) begin
			capacity = `CRC_CAP_NARROW;
		end else if (dataWidth_reg <= `CRC_WIDTH_MEDIUM_MAX) begin
			capacity = `CRC_CAP_MEDIUM;
		end else begin
			capacity = `CRC_CAP_WIDE;
		end
	end

	assign isFull = wordCount_reg >= capacity;
	assign pushNow = wrDataLow && !isFull;
	assign pushWord = wideData ? {dataHigh_reg, sfrReq.wrData} :
		{16'h0000, sfrReq.wrData};

	always_ff @(posedge clock) begin
		if (pushNow) begin
			fifoMem[wrPtr_reg] <= pushWord;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wrPtr_reg <= 4'h0;
		end else if (pushNow) begin
			wrPtr_reg <= wrPtr_reg + 4'h1;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdPtr_reg <= 4'h0;
		end else if (popNow) begin
			rdPtr_reg <= rdPtr_reg + 4'h1;
		end
	end
	always_comb begin
		wordCount_next = wordCount_reg;
		if (pushNow && !popNow) begin
			wordCount_next = wordCount_reg + 5'h01;
		end else if (popNow && !pushNow) begin
			wordCount_next = wordCount_reg - 5'h01;
		end
	end

	// flags follow the new count in the same edge as the counter
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wordCount_reg <= 5'h00;
			fullFlag_reg <= 1'b0;
			emptyFlag_reg <= `CRC_EMPTY_RESET;
		end else begin
			wordCount_reg <= wordCount_next;
			fullFlag_reg <= wordCount_next >= capacity;
			emptyFlag_reg <= wordCount_next == 5'h00;
		end
	end

	// engine sequencing
	assign engineRun = moduleEnable_reg && goBit_reg &&
		!(idleStop_reg && idleMode);
	assign popNow = engineRun && wordCount_reg != 5'h00 &&
		(state_reg == CRC_IDLE || bitCnt_reg == 5'h00);
	assign doneNow = engineRun && state_reg == CRC_SHIFT &&
		bitCnt_reg == 5'h00 && wordCount_reg == 5'h00;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= CRC_IDLE;
			bitCnt_reg <= 5'h00;
			word_reg <= 32'h00000000;
		end else begin
			case (state_reg)
				CRC_IDLE: begin
					if (popNow) begin
						state_reg <= CRC_SHIFT;
						bitCnt_reg <= dataWidth_reg;
						word_reg <= fifoMem[rdPtr_reg];
					end
				end
				CRC_SHIFT: begin
					if (!goBit_reg || !moduleEnable_reg) begin
						state_reg <= CRC_IDLE;
					end else if (engineRun) begin
						if (popNow) begin
							bitCnt_reg <= dataWidth_reg;
							word_reg <= fifoMem[rdPtr_reg];
						end else if (bitCnt_reg == 5'h00) begin
							state_reg <= CRC_IDLE;
						end else begin
							bitCnt_reg <= bitCnt_reg - 5'h01;
							word_reg <= lsbFirst_reg ? word_reg >> 1 :
								word_reg << 1;
						end
					end
				end
				default: begin
					state_reg <= CRC_IDLE;
				end
			endcase
		end
	end

	// one bit per shift through the programmable xor stages
	always_comb begin
		bitIn = lsbFirst_reg ? word_reg[0] : word_reg[dataWidth_reg];
		feedback = shift_reg[polyLen_reg] ^ bitIn;
		lenMask = 32'h00000000;
		shift_next = 32'h00000000;
		for (int i = 0; i < 32; i++) begin
			lenMask[i] = 5'(i) <= polyLen_reg;
		end
		shift_next[0] = feedback;
		for (int i = 1; i < 32; i++) begin
			shift_next[i] = shift_reg[i-1] ^ (feedback & polyTerms_reg[i]);
		end
		shift_next = shift_next & lenMask;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			shift_reg <= 32'h00000000;
		end else if (wrResLow) begin
			shift_reg[15:0] <= sfrReq.wrData;
		end else if (wrResHigh) begin
			shift_reg[31:16] <= sfrReq.wrData;
		end else if (state_reg == CRC_SHIFT && engineRun) begin
			shift_reg <= shift_next;
		end
	end

	// interrupt pulse from either selected source
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (irqSel_reg && popNow && !pushNow &&
				wordCount_reg == 5'h01) ||
				(!irqSel_reg && doneNow);
		end
	end

	// registered read port
	always_comb begin
		rdValue = 16'h0000;
		case (sfrReq.addr)
			`CRC_IDX_CTRL_ONE: begin
				rdValue[`CRC_BIT_ENABLE] = moduleEnable_reg;
				rdValue[`CRC_BIT_IDLE_STOP] = idleStop_reg;
				rdValue[`CRC_COUNT_LSB +: 5] = wordCount_reg;
				rdValue[`CRC_BIT_FULL] = fullFlag_reg;
				rdValue[`CRC_BIT_EMPTY] = emptyFlag_reg;
				rdValue[`CRC_BIT_IRQ_SEL] = irqSel_reg;
				rdValue[`CRC_BIT_GO] = goBit_reg;
				rdValue[`CRC_BIT_LSB_FIRST] = lsbFirst_reg;
			end
			`CRC_IDX_CTRL_TWO: begin
				rdValue[`CRC_WIDTH_LSB +: 5] = dataWidth_reg;
				rdValue[`CRC_LEN_LSB +: 5] = polyLen_reg;
			end
			`CRC_IDX_TERMS_LOW: begin
				rdValue = {polyTerms_reg[15:1], 1'b0};
			end
			`CRC_IDX_TERMS_HIGH: begin
				rdValue = polyTerms_reg[31:16];
			end
			`CRC_IDX_RESULT_LOW: begin
				rdValue = shift_reg[15:0];
			end
			`CRC_IDX_RESULT_HIGH: begin
				rdValue = shift_reg[31:16];
			end
			default: begin
				rdValue = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdData_reg <= 16'h0000;
		end else if (sfrReq.rdEn) begin
			rdData_reg <= rdValue;
		end
	end

	assign sfrRdData = rdData_reg;
	assign crcIrq = irq_reg;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence wordLoad;
		state_reg == CRC_IDLE && popNow ##1 state_reg == CRC_SHIFT;
	endsequence
	sequence lastPop;
		irqSel_reg && popNow && !pushNow && wordCount_reg == 5'h01;
	endsequence
	enable_gate_a: assert property (
		!moduleEnable_reg |=> state_reg == CRC_IDLE)
		else $error("engine shifting with module disabled");
	idle_halt_a: assert property (
		idleStop_reg && idleMode && !wrResLow && !wrResHigh |=>
			$stable(shift_reg))
		else $error("shifter moved during idle stop");
	count_cap_a: assert property (
		$rose(fullFlag_reg) && $stable(dataWidth_reg) &&
			$past(dataWidth_reg, 2) == dataWidth_reg |-> wordCount_reg ==
			(wideData ? `CRC_CAP_WIDE : dataWidth_reg > `CRC_WIDTH_NARROW_MAX ?
			`CRC_CAP_MEDIUM : `CRC_CAP_NARROW))
		else $error("fifo full at a depth the width does not give");
	empty_flag_a: assert property (
		emptyFlag_reg == (wordCount_reg == 5'h00) &&
			(!emptyFlag_reg || wrPtr_reg == rdPtr_reg))
		else $error("empty flag disagrees with count or pointers");
	full_drop_a: assert property (
		wrDataLow && isFull && !popNow |=> $stable(wordCount_reg))
		else $error("write while full changed the count");
	pop_dec_a: assert property (
		popNow && !pushNow |=> wordCount_reg == $past(wordCount_reg) - 5'h01)
		else $error("pop did not decrement count");
	irq_empty_a: assert property (
		lastPop |=> crcIrq)
		else $error("no interrupt when fifo emptied");
	irq_done_a: assert property (
		crcIrq && !$past(irqSel_reg) |-> state_reg == CRC_IDLE &&
			$past(state_reg) == CRC_SHIFT && $past(bitCnt_reg) == 5'h00)
		else $error("shift-done interrupt without completion");
	abort_stop_a: assert property (
		state_reg == CRC_SHIFT && !goBit_reg |=> state_reg == CRC_IDLE)
		else $error("clearing start did not abort");
	load_width_a: assert property (
		wordLoad |-> bitCnt_reg == $past(dataWidth_reg))
		else $error("bit count not loaded from width");
	read_zero_a: assert property (
		sfrReq.rdEn && (sfrReq.addr == `CRC_IDX_DATA_LOW ||
			sfrReq.addr == `CRC_IDX_DATA_HIGH) |=> sfrRdData == 16'h0000)
		else $error("data register read not zero");
endmodule : crc_generator

// >>> core/crc_defs.svh
// register indexes, field positions, reset values and sizes of the crc block
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

`define CRC_ADDR_W 3
`define CRC_IDX_CTRL_ONE 3'h0
`define CRC_IDX_CTRL_TWO 3'h1
`define CRC_IDX_TERMS_LOW 3'h2
`define CRC_IDX_TERMS_HIGH 3'h3
`define CRC_IDX_DATA_LOW 3'h4
`define CRC_IDX_DATA_HIGH 3'h5
`define CRC_IDX_RESULT_LOW 3'h6
`define CRC_IDX_RESULT_HIGH 3'h7

`define CRC_BIT_ENABLE 15
`define CRC_BIT_IDLE_STOP 13
`define CRC_COUNT_LSB 8
`define CRC_BIT_FULL 7
`define CRC_BIT_EMPTY 6
`define CRC_BIT_IRQ_SEL 5
`define CRC_BIT_GO 4
`define CRC_BIT_LSB_FIRST 3
`define CRC_WIDTH_LSB 8
`define CRC_LEN_LSB 0

`define CRC_EMPTY_RESET 1'b1
`define CRC_FIFO_SLOTS 16
`define CRC_CAP_NARROW 5'h10
`define CRC_CAP_MEDIUM 5'h08
`define CRC_CAP_WIDE 5'h04
`define CRC_WIDTH_NARROW_MAX 5'h07
`define CRC_WIDTH_MEDIUM_MAX 5'h0f

`endif

// >>> core/crc_pkg.sv
// types shared by the crc block
package crc_pkg;
	typedef enum logic {CRC_IDLE, CRC_SHIFT} crc_state_t;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [2:0] addr;
		logic [15:0] wrData;
	} crc_sfr_req_t;
endpackage : crc_pkg

// >>> verification/tb.sv
// self-checking bench for the crc generator
`timescale 1ns/1ps
`include "crc_defs.svh"
module tb;
import crc_pkg::*;
typedef struct {
	logic [4:0] w;
	logic [4:0] p;
	logic [31:0] t;
	logic [31:0] d;
	logic [31:0] s;
	logic lsb;
} crc_row_t;
logic clock = 1'b0;
logic rst_n = 1'b0;
logic idleMode = 1'b0;
crc_sfr_req_t sfrReq = '0;
logic [15:0] sfrRdData;
logic crcIrq;
int miscompares = 0;
int checks = 0;
logic [15:0] rv;
logic [31:0] got;
logic [31:0] exp;
logic [31:0] prev;
crc_row_t rows [6];
logic [4:0] wd [3] = '{5'h07, 5'h0f, 5'h1f};
logic [4:0] dp [3] = '{5'h10, 5'h08, 5'h04};
int k;
int i;

crc_generator dut_u (
	.clock(clock),
	.rst_n(rst_n),
	.idleMode(idleMode),
	.sfrReq(sfrReq),
	.sfrRdData(sfrRdData),
	.crcIrq(crcIrq)
);

always #5 clock = ~clock;

task automatic check(input logic [31:0] seen, input logic [31:0] want);
	checks++;
	if (seen !== want) begin
		miscompares++;
		$display("Error %0t: got %h want %h", $time, seen, want);
	end
endtask : check

task automatic wr(input logic [2:0] a, input logic [15:0] d);
	@(posedge clock);
	sfrReq <= '{1'b1, 1'b0, a, d};
	@(posedge clock);
	sfrReq <= '0;
endtask : wr

// read data is registered, so sample one edge after the taken edge
task automatic rd(input logic [2:0] a);
	@(posedge clock);
	sfrReq <= '{1'b0, 1'b1, a, 16'h0};
	@(posedge clock);
	sfrReq <= '0;
	@(posedge clock);
	#1 rv = sfrRdData;
endtask : rd

task automatic res(output logic [31:0] r);
	rd(`CRC_IDX_RESULT_LOW);
	r[15:0] = rv;
	rd(`CRC_IDX_RESULT_HIGH);
	r[31:16] = rv;
endtask : res

task automatic waitIrq(input int n, input logic want);
	logic seen;
	seen = 1'b0;
	for (int c = 0; c < n && !seen; c++) begin
		@(posedge clock);
		#1 seen = (crcIrq === 1'b1);
	end
	check(seen, want);
endtask : waitIrq

task automatic doReset(input int n);
	@(posedge clock);
	rst_n <= 1'b0;
	repeat (n) @(posedge clock);
	rst_n <= 1'b1;
endtask : doReset

// one serial step per data bit, feedback from the tap at the length
function automatic logic [31:0] crcRef(input logic [31:0] s,
	input logic [31:0] d, input logic [31:0] t, input logic [4:0] w,
	input logic [4:0] p, input logic lsb);
	logic fb;
	logic [31:0] n;
	s = s & (32'hffffffff >> (5'h1f - p));
	for (int b = 0; b <= w; b++) begin
		fb = s[p] ^ d[lsb ? b : w - b];
		n = '0;
		n[0] = fb;
		for (int j = 1; j <= p; j++)
			n[j] = s[j - 1] ^ (fb & t[j]);
		s = n;
	end
	return s;
endfunction : crcRef

task automatic summarize;
	$display("checks %0d miscompares %0d", checks, miscompares);
	if (miscompares == 0 && checks > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask : summarize

initial begin
	repeat (20000) @(posedge clock);
	miscompares++;
	summarize();
end

initial begin
	rows[0] = '{5'h07, 5'h0f, 32'h1020, 32'h31, 32'hffff, 1'b0};
	rows[1] = '{5'h07, 5'h0f, 32'h1020, 32'h31, 32'hffff, 1'b1};
	rows[2] = '{5'h0f, 5'h0f, 32'h1021, 32'hbeef1234, 32'h0, 1'b0};
	rows[3] = '{5'h1f, 5'h1f, 32'h04c11db6, 32'hdeadbeef, '1, 1'b1};
	rows[4] = '{5'h00, 5'h04, 32'h0d, 32'h1, 32'h1f, 1'b0};
	rows[5] = '{5'h14, 5'h07, 32'h0e, 32'h0abcde, 32'h5a, 1'b1};
	repeat (16) @(posedge clock);
	rst_n <= 1'b1;
	for (k = 0; k < 8; k++) begin
		rd(k[2:0]);
		check(rv, k == 0 ? 16'h0040 : 16'h0);
	end
	wr(`CRC_IDX_CTRL_ONE, 16'h6007);
	rd(`CRC_IDX_CTRL_ONE);
	check(rv, 16'h2040);
	wr(`CRC_IDX_CTRL_TWO, 16'hffff);
	rd(`CRC_IDX_CTRL_TWO);
	check(rv, 16'h1f1f);
	$display("reset and field tests done");
	@(posedge clock);
	idleMode <= 1'b1;
	for (k = 0; k < 6; k++) begin
		wr(`CRC_IDX_CTRL_ONE, 16'h0);
		wr(`CRC_IDX_CTRL_TWO, {3'h0, rows[k].w, 3'h0, rows[k].p});
		wr(`CRC_IDX_TERMS_LOW, rows[k].t[15:0]);
		wr(`CRC_IDX_TERMS_HIGH, rows[k].t[31:16]);
		wr(`CRC_IDX_RESULT_LOW, rows[k].s[15:0]);
		wr(`CRC_IDX_RESULT_HIGH, rows[k].s[31:16]);
		rd(`CRC_IDX_TERMS_LOW);
		check(rv, {rows[k].t[15:1], 1'b0});
		wr(`CRC_IDX_DATA_HIGH, rows[k].d[31:16]);
		wr(`CRC_IDX_DATA_LOW, rows[k].d[15:0]);
		wr(`CRC_IDX_CTRL_ONE, {8'h80, 4'h1, rows[k].lsb, 3'h0});
		waitIrq(80, 1'b1);
		res(got);
		exp = crcRef(rows[k].s, rows[k].d, rows[k].t, rows[k].w,
			rows[k].p, rows[k].lsb);
		check(got, exp);
		rd(`CRC_IDX_CTRL_ONE);
		check(rv, {8'h80, 4'h5, rows[k].lsb, 3'h0});
		$display("row %0d done", k);
	end
	for (k = 0; k < 3; k++) begin
		doReset(2);
		wr(`CRC_IDX_DATA_HIGH, 16'hffff);
		wr(`CRC_IDX_CTRL_TWO, {3'h0, wd[k], 8'h1f});
		for (i = 0; i <= dp[k]; i++)
			wr(`CRC_IDX_DATA_LOW, 16'h100 + i[15:0]);
		rd(`CRC_IDX_CTRL_ONE);
		check(rv, {3'h0, dp[k], 8'h80});
	end
	wr(`CRC_IDX_TERMS_LOW, 16'h1db6);
	wr(`CRC_IDX_TERMS_HIGH, 16'h04c1);
	wr(`CRC_IDX_CTRL_ONE, 16'h8030);
	waitIrq(200, 1'b1);
	rd(`CRC_IDX_CTRL_ONE);
	check(rv & 16'h1fc0, 16'h0040);
	// the last word needs width plus one shifts after its pop
	repeat (40) @(posedge clock);
	res(got);
	exp = '0;
	for (i = 0; i < 4; i++)
		exp = crcRef(exp, 32'h100 + i, 32'h04c11db6, 5'h1f, 5'h1f, 1'b0);
	check(got, exp);
	$display("fifo tests done");
	wr(`CRC_IDX_DATA_LOW, 16'h5555);
	wr(`CRC_IDX_CTRL_ONE, 16'h8010);
	repeat (5) @(posedge clock);
	wr(`CRC_IDX_CTRL_ONE, 16'h8000);
	waitIrq(60, 1'b0);
	res(prev);
	repeat (10) @(posedge clock);
	res(got);
	check(got, prev);
	wr(`CRC_IDX_CTRL_ONE, 16'h0010);
	wr(`CRC_IDX_DATA_LOW, 16'h00aa);
	repeat (10) @(posedge clock);
	rd(`CRC_IDX_CTRL_ONE);
	check(rv, 16'h0110);
	wr(`CRC_IDX_CTRL_ONE, 16'ha010);
	waitIrq(60, 1'b0);
	@(posedge clock);
	idleMode <= 1'b0;
	waitIrq(60, 1'b1);
	$display("abort and idle tests done");
	summarize();
end
endmodule : tb
